/* File: pcr_defs.svh */
// constants of the phy control register block
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// -----------------------------------------------------------------
// addresses and reset values
// -----------------------------------------------------------------
`define PCR_ADDR_CONTROL      5'h00
`define PCR_RESET_VALUE       16'h3100
`define PCR_READ_UNMAPPED     16'h0000

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PCR_BIT_SOFT_RESET    15
`define PCR_BIT_LOOPBACK      14
`define PCR_BIT_LINE_RATE     13
`define PCR_BIT_NEGOTIATION   12

// -----------------------------------------------------------------
// timing counts, in i_clk cycles
// -----------------------------------------------------------------
`define PCR_SOFT_RESET_CYCLES 16

`endif

/* File: pcr_pkg.sv */
// types shared by the phy control register block
`default_nettype none

package pcr_pkg;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef logic [15:0] pcr_word_type;

  typedef enum logic [0:0] {
    PCR_ST_RUN  = 1'b0,
    PCR_ST_SRST = 1'b1
  } pcr_state_type;

  typedef logic [3:0] pcr_nibble_type;

endpackage

`default_nettype wire

/* File: pcr_ctl_if.sv */
// control carrier from the register bank to the data path
`timescale 1ns/1ps
`default_nettype none

interface pcr_ctl_if;
  logic loopback;
  logic core_reset;

  modport ctl (output loopback, output core_reset);
  modport path (input loopback, input core_reset);
endinterface

`default_nettype wire

/* File: pcr_loop_path.sv */
// nibble data path with loopback steering
`timescale 1ns/1ps
`default_nettype none

module pcr_loop_path (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  pcr_ctl_if.path             ctl,
  input  wire logic [3:0]     i_tx_data,
  input  wire logic           i_tx_en,
  input  wire logic [3:0]     i_line_rx_data,
  input  wire logic           i_line_rx_dv,
  output var  logic [3:0]     o_rx_data,
  output var  logic           o_rx_dv,
  output var  logic [3:0]     o_line_tx_data,
  output var  logic           o_line_tx_en
);

  // -----------------------------------------------------------------
  // line input synchroniser
  // -----------------------------------------------------------------
  logic [4:0] meta_q;
  logic [4:0] line_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 5'h00;
      line_q <= 5'h00;
    end else begin
      meta_q <= {i_line_rx_dv, i_line_rx_data};
      line_q <= meta_q;
    end
  end

  // -----------------------------------------------------------------
  // steering
  // -----------------------------------------------------------------
  pcr_pkg::pcr_nibble_type rx_data_d, tx_data_d;
  logic                    rx_dv_d, tx_en_d;

  // loopback cuts the medium off both ways
  always_comb begin
    rx_data_d = 4'h0;
    rx_dv_d   = 1'b0;
    tx_data_d = 4'h0;
    tx_en_d   = 1'b0;
    if (!ctl.core_reset) begin
      if (ctl.loopback) begin
        rx_data_d = i_tx_data;
        rx_dv_d   = i_tx_en;
      end else begin
        rx_data_d = line_q[3:0];
        rx_dv_d   = line_q[4];
        tx_data_d = i_tx_data;
        tx_en_d   = i_tx_en;
      end
    end
  end

  // output registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rx_data      <= 4'h0;
      o_rx_dv        <= 1'b0;
      o_line_tx_data <= 4'h0;
      o_line_tx_en   <= 1'b0;
    end else begin
      o_rx_data      <= rx_data_d;
      o_rx_dv        <= rx_dv_d;
      o_line_tx_data <= tx_data_d;
      o_line_tx_en   <= tx_en_d;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_loop_returns;
    @(posedge i_clk) disable iff (i_rst)
    (ctl.loopback && !ctl.core_reset && i_tx_en)
      |=> (o_rx_dv && o_rx_data == $past(i_tx_data));
  endproperty
  a_loop_returns: assert property (p_loop_returns)
    else $error("looped data did not return on receive side");

  property p_loop_isolates;
    @(posedge i_clk) disable iff (i_rst)
    ctl.loopback |=> !o_line_tx_en;
  endproperty
  a_loop_isolates: assert property (p_loop_isolates)
    else $error("medium driven while in loopback");

  property p_loop_ignores_line;
    @(posedge i_clk) disable iff (i_rst)
    (ctl.loopback && !i_tx_en) |=> !o_rx_dv;
  endproperty
  a_loop_ignores_line: assert property (p_loop_ignores_line)
    else $error("medium receive leaked into loopback");

  property p_reset_blanks;
    @(posedge i_clk) disable iff (i_rst)
    ctl.core_reset |=> (!o_rx_dv && !o_line_tx_en);
  endproperty
  a_reset_blanks: assert property (p_reset_blanks)
    else $error("data path active during soft reset");

  c_loop_frame: cover property (@(posedge i_clk) disable iff (i_rst)
    ctl.loopback && i_tx_en ##1 o_rx_dv);

endmodule

`default_nettype wire

/* File: pcr_phy_control_register.sv */
// phy control register at management address zero with loopback path
`include "pcr_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcr_phy_control_register #(
  parameter int SOFT_RESET_CYCLES = `PCR_SOFT_RESET_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_mgmt_addr,
  input  wire logic        i_mgmt_wr,
  input  wire logic        i_mgmt_rd,
  input  wire logic [15:0] i_mgmt_write_word,
  output var  logic [15:0] o_mgmt_rd_data,
  output var  logic        o_mgmt_rd_valid,
  output var  logic [15:0] o_phy_control,
  output var  logic        o_loopback_enable,
  output var  logic        o_line_rate_select,
  output var  logic        o_negotiation_enable,
  output var  logic        o_core_reset,
  input  wire logic [3:0]  i_tx_data,
  input  wire logic        i_tx_en,
  input  wire logic [3:0]  i_line_rx_data,
  input  wire logic        i_line_rx_dv,
  output var  logic [3:0]  o_rx_data,
  output var  logic        o_rx_dv,
  output var  logic [3:0]  o_line_tx_data,
  output var  logic        o_line_tx_en
);

  // -----------------------------------------------------------------
  // constants
  // -----------------------------------------------------------------
  localparam logic [7:0] SRST_LAST = 8'(SOFT_RESET_CYCLES - 1);
  localparam pcr_pkg::pcr_word_type SRST_WORD =
    `PCR_RESET_VALUE | (16'h0001 << `PCR_BIT_SOFT_RESET);
  localparam int SRST_MAX = SOFT_RESET_CYCLES + 1;

  // -----------------------------------------------------------------
  // register bank state
  // -----------------------------------------------------------------
  pcr_pkg::pcr_word_type  ctrl_q, ctrl_d;
  pcr_pkg::pcr_word_type  rd_data_q, rd_data_d;
  pcr_pkg::pcr_state_type state_q, state_d;
  logic [7:0]             cnt_q, cnt_d;
  logic                   rd_valid_q, rd_valid_d;
  logic                   hit_wr;

  assign hit_wr = i_mgmt_wr && (i_mgmt_addr == `PCR_ADDR_CONTROL);

  // next values: writes, soft reset sequence, reads
  always_comb begin
    ctrl_d     = ctrl_q;
    state_d    = state_q;
    cnt_d      = cnt_q;
    rd_data_d  = rd_data_q;
    rd_valid_d = 1'b0;
    unique case (state_q)
      pcr_pkg::PCR_ST_RUN: begin
        if (hit_wr) begin
          if (i_mgmt_write_word[`PCR_BIT_SOFT_RESET]) begin
            state_d = pcr_pkg::PCR_ST_SRST;
            cnt_d   = 8'h00;
            ctrl_d  = SRST_WORD;
          end else begin
            ctrl_d = i_mgmt_write_word;
          end
        end
      end
      pcr_pkg::PCR_ST_SRST: begin
        // bank held at defaults plus the soft reset bit; a new request restarts, never lost
        ctrl_d = SRST_WORD;
        if (hit_wr && i_mgmt_write_word[`PCR_BIT_SOFT_RESET]) begin
          cnt_d = 8'h00;
        end else if (cnt_q == SRST_LAST) begin
          state_d = pcr_pkg::PCR_ST_RUN;
          ctrl_d  = `PCR_RESET_VALUE;             // self clear
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
    endcase
    if (i_mgmt_rd) begin
      rd_valid_d = 1'b1;
      rd_data_d  = (i_mgmt_addr == `PCR_ADDR_CONTROL) ?
                   ctrl_q : `PCR_READ_UNMAPPED;
    end
  end

  // registers; reset lands in normal operation
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q     <= `PCR_RESET_VALUE;
      state_q    <= pcr_pkg::PCR_ST_RUN;
      cnt_q      <= 8'h00;
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  // -----------------------------------------------------------------
  // control outputs, all straight from flops
  // -----------------------------------------------------------------
  assign o_mgmt_rd_data       = rd_data_q;
  assign o_mgmt_rd_valid      = rd_valid_q;
  assign o_phy_control        = ctrl_q;
  assign o_loopback_enable    = ctrl_q[`PCR_BIT_LOOPBACK];
  assign o_line_rate_select   = ctrl_q[`PCR_BIT_LINE_RATE];
  assign o_negotiation_enable = ctrl_q[`PCR_BIT_NEGOTIATION];
  assign o_core_reset         = (state_q == pcr_pkg::PCR_ST_SRST);

  // -----------------------------------------------------------------
  // data path
  // -----------------------------------------------------------------
  pcr_ctl_if ctl_bus ();

  // data path sees the soft reset so its outputs drop too
  assign ctl_bus.loopback   = ctrl_q[`PCR_BIT_LOOPBACK];
  assign ctl_bus.core_reset = (state_q == pcr_pkg::PCR_ST_SRST);

  pcr_loop_path u_path (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .ctl            (ctl_bus.path),
    .i_tx_data      (i_tx_data),
    .i_tx_en        (i_tx_en),
    .i_line_rx_data (i_line_rx_data),
    .i_line_rx_dv   (i_line_rx_dv),
    .o_rx_data      (o_rx_data),
    .o_rx_dv        (o_rx_dv),
    .o_line_tx_data (o_line_tx_data),
    .o_line_tx_en   (o_line_tx_en)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_reset_value;
    $fell(i_rst) |-> (o_phy_control == `PCR_RESET_VALUE
                      && !o_core_reset);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("control word wrong after reset");

  property p_write_store;
    (state_q == pcr_pkg::PCR_ST_RUN && hit_wr
     && !i_mgmt_write_word[`PCR_BIT_SOFT_RESET])
      |=> o_phy_control == $past(i_mgmt_write_word);
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("written word not stored");

  property p_read_back;
    (i_mgmt_rd && i_mgmt_addr == `PCR_ADDR_CONTROL)
      |=> (o_mgmt_rd_valid && o_mgmt_rd_data == $past(o_phy_control));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read did not return control word");

  property p_srst_enter;
    (state_q == pcr_pkg::PCR_ST_RUN && hit_wr
     && i_mgmt_write_word[`PCR_BIT_SOFT_RESET])
      |=> (o_core_reset && o_phy_control == SRST_WORD);
  endproperty
  a_srst_enter: assert property (p_srst_enter)
    else $error("soft reset not entered");

  property p_srst_ends;
    $rose(o_core_reset) |-> ##[1:SRST_MAX] !o_core_reset;
  endproperty
  a_srst_ends: assert property (p_srst_ends)
    else $error("soft reset did not finish in time");

  property p_srst_clears;
    $fell(o_core_reset) |-> o_phy_control == `PCR_RESET_VALUE;
  endproperty
  a_srst_clears: assert property (p_srst_clears)
    else $error("soft reset left bank off defaults");

  property p_rate_follows;
    (state_q == pcr_pkg::PCR_ST_RUN && hit_wr
     && !i_mgmt_write_word[`PCR_BIT_SOFT_RESET])
      |=> o_line_rate_select
          == $past(i_mgmt_write_word[`PCR_BIT_LINE_RATE]);
  endproperty
  a_rate_follows: assert property (p_rate_follows)
    else $error("line rate did not follow write");

  property p_neg_follows;
    (state_q == pcr_pkg::PCR_ST_RUN && hit_wr
     && !i_mgmt_write_word[`PCR_BIT_SOFT_RESET])
      |=> o_negotiation_enable
          == $past(i_mgmt_write_word[`PCR_BIT_NEGOTIATION]);
  endproperty
  a_neg_follows: assert property (p_neg_follows)
    else $error("negotiation enable did not follow write");

  c_soft_reset: cover property ($fell(o_core_reset));
  c_slow_rate: cover property ($fell(o_line_rate_select));
  c_loop_on: cover property ($rose(o_loopback_enable));

endmodule

`default_nettype wire

/* File: pcr_mgmt_master.sv */
// management master model that drives the control register bus
`timescale 1ns/1ps
`default_nettype none

module pcr_mgmt_master (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  output var  logic [4:0]  o_addr,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [15:0] o_word
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    o_addr = 5'h00;
    o_wr   = 1'b0;
    o_rd   = 1'b0;
    o_word = 16'h0000;
  end

  // one-cycle write strobe; word inverted after so stale data never helps
  task automatic write(input logic [4:0] a, input logic [15:0] w);
    @(posedge i_clk);
    o_addr <= a;
    o_word <= w;
    o_wr   <= 1'b1;
    @(posedge i_clk);
    o_wr   <= 1'b0;
    o_word <= ~w;
    #1;
  endtask

  // one-cycle read strobe; answer taken one cycle after the strobe
  task automatic read(input logic [4:0] a, output logic [15:0] d,
                      output logic v);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    #1;
    d = i_rd_data;
    v = i_rd_valid;
  endtask
endmodule

`default_nettype wire

/* File: tb.sv */
// self-checking bench of the phy control register block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin \
  samples_checked++; \
  if ((gt) !== (ex)) begin \
    mismatches++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); \
  end \
end

module tb;
  localparam int SRC = 4;  // short soft reset keeps the run brief

  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [4:0]  addr;
  logic        wr, rd, rd_valid, loop_en, rate, neg, core_rst;
  logic [15:0] word, rd_data, ctrl, d;
  logic        v, rx_dv, ltx_en;
  logic [3:0]  rx_data, ltx_data;
  logic [3:0]  tx_data  = 4'h0;
  logic        tx_en    = 1'b0;
  logic [3:0]  lrx_data = 4'h0;
  logic        lrx_dv   = 1'b0;
  int          mismatches = 0;
  int          samples_checked = 0;

  always #5 i_clk = ~i_clk;

  pcr_mgmt_master mgmt (.i_clk(i_clk), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_word(word));

  pcr_phy_control_register #(.SOFT_RESET_CYCLES(SRC)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_mgmt_addr(addr), .i_mgmt_wr(wr),
    .i_mgmt_rd(rd), .i_mgmt_write_word(word), .o_mgmt_rd_data(rd_data),
    .o_mgmt_rd_valid(rd_valid), .o_phy_control(ctrl),
    .o_loopback_enable(loop_en), .o_line_rate_select(rate),
    .o_negotiation_enable(neg), .o_core_reset(core_rst),
    .i_tx_data(tx_data), .i_tx_en(tx_en), .i_line_rx_data(lrx_data),
    .i_line_rx_dv(lrx_dv), .o_rx_data(rx_data), .o_rx_dv(rx_dv),
    .o_line_tx_data(ltx_data), .o_line_tx_en(ltx_en));

  // ---------------------------------------------------------------
  // closing
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // defaults straight out of reset
  task automatic t_defaults();
    `CHK("ctrl", 16'h3100, ctrl)
    `CHK("loop", 1'b0, loop_en)
    `CHK("core", 1'b0, core_rst)
    `CHK("rate", 1'b1, rate)
    `CHK("neg", 1'b1, neg)
    `CHK("rdv", 1'b0, rd_valid)
    mgmt.read(5'h00, d, v);
    `CHK("rdv", 1'b1, v)
    `CHK("rd", 16'h3100, d)
    @(posedge i_clk);
    #1;
    `CHK("rdv", 1'b0, rd_valid)
  endtask

  // field writes, readback, and an unmapped address
  task automatic t_write_read();
    mgmt.write(5'h00, 16'h0155);
    `CHK("ctrl", 16'h0155, ctrl)
    `CHK("rate", 1'b0, rate)
    `CHK("neg", 1'b0, neg)
    mgmt.read(5'h00, d, v);
    `CHK("rd", 16'h0155, d)
    mgmt.write(5'h00, 16'h2000);
    `CHK("rate", 1'b1, rate)
    `CHK("neg", 1'b0, neg)
    mgmt.write(5'h01, 16'hffff);
    `CHK("ctrl", 16'h2000, ctrl)
    mgmt.read(5'h01, d, v);
    `CHK("rdv", 1'b1, v)
    `CHK("rd", 16'h0000, d)
    mgmt.write(5'h00, 16'h3100);
  endtask

  // normal mode: nibble to the line, line nibble to the user
  task automatic t_normal();
    @(posedge i_clk);
    tx_data  <= 4'ha;
    tx_en    <= 1'b1;
    lrx_data <= 4'h5;
    lrx_dv   <= 1'b1;
    @(posedge i_clk);
    tx_en    <= 1'b0;
    tx_data  <= 4'h5;
    lrx_dv   <= 1'b0;
    lrx_data <= 4'ha;
    #1;
    `CHK("ltx", 4'ha, ltx_data)
    `CHK("ltxen", 1'b1, ltx_en)
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("rx", 4'h5, rx_data)
    `CHK("rxdv", 1'b1, rx_dv)
  endtask

  // loopback: tx returns on rx, line held busy but ignored
  task automatic t_loopback();
    mgmt.write(5'h00, 16'h7100);
    `CHK("loop", 1'b1, loop_en)
    @(posedge i_clk);
    tx_data  <= 4'h6;
    tx_en    <= 1'b1;
    lrx_data <= 4'h9;
    lrx_dv   <= 1'b1;
    @(posedge i_clk);
    tx_en    <= 1'b0;
    tx_data  <= 4'h9;
    #1;
    `CHK("rx", 4'h6, rx_data)
    `CHK("rxdv", 1'b1, rx_dv)
    `CHK("ltxen", 1'b0, ltx_en)
    repeat (3) @(posedge i_clk);
    lrx_dv <= 1'b0;
    #1;
    `CHK("rxdv", 1'b0, rx_dv)
  endtask

  // soft reset from loopback: bit reads set, then clears with defaults
  task automatic t_soft_reset();
    // traffic both ways so that blanking during the reset can show
    @(posedge i_clk);
    tx_en  <= 1'b1;
    lrx_dv <= 1'b1;
    mgmt.write(5'h00, 16'hc000);
    `CHK("core", 1'b1, core_rst)
    `CHK("ctrl", 16'hb100, ctrl)
    repeat (SRC - 1) begin
      @(posedge i_clk);
      #1;
      `CHK("core", 1'b1, core_rst)
      `CHK("rxdv", 1'b0, rx_dv)
      `CHK("ltxen", 1'b0, ltx_en)
    end
    @(posedge i_clk);
    tx_en  <= 1'b0;
    lrx_dv <= 1'b0;
    #1;
    `CHK("ltxen", 1'b0, ltx_en)
    `CHK("core", 1'b0, core_rst)
    `CHK("ctrl", 16'h3100, ctrl)
    `CHK("loop", 1'b0, loop_en)
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    t_defaults();
    t_write_read();
    t_normal();
    t_loopback();
    t_soft_reset();
    end_of_test();
  end

  // whole run is about fifty cycles; this leaves wide margin
  initial begin
    #20000;
    mismatches++;
    end_of_test();
  end
endmodule

`default_nettype wire
